// ---- rtl/circ_pkg.sv ----
// Shared constants and types for the interrupt and reset control unit
`default_nettype none
package circ_pkg;
	// ------------------------------------------------------------
	// Timing
	// ------------------------------------------------------------
	localparam int         REF_CLK_NS   = 25;
	localparam int         PROC_CYC_NS  = 100;
	localparam int         CYC_CLKS     = (PROC_CYC_NS + REF_CLK_NS - 1) / REF_CLK_NS;
	localparam logic [1:0] PH1_START    = 2'h0;
	localparam logic [1:0] PH1_TRAIL    = 2'h1;
	localparam logic [1:0] PH2_SAMPLE   = 2'h3;
	localparam logic [1:0] PH_LAST      = 2'(CYC_CLKS - 1);
	localparam logic [2:0] RST_INIT_CYC = 3'h6;
	localparam logic [1:0] RST_HOLD_CYC = 2'h2;
	// ------------------------------------------------------------
	// Vectors
	// ------------------------------------------------------------
	localparam logic [15:0] NMI_VEC_LO = 16'hFFFA;
	localparam logic [15:0] NMI_VEC_HI = 16'hFFFB;
	localparam logic [15:0] RST_VEC_LO = 16'hFFFC;
	localparam logic [15:0] RST_VEC_HI = 16'hFFFD;
	localparam logic [15:0] IRQ_VEC_LO = 16'hFFFE;
	localparam logic [15:0] IRQ_VEC_HI = 16'hFFFF;
	// ------------------------------------------------------------
	// Types
	// ------------------------------------------------------------
	typedef enum logic [7:0] {
		CIRC_HOLD   = 8'h01,
		CIRC_WAIT   = 8'h02,
		CIRC_PUSH_H = 8'h04,
		CIRC_PUSH_L = 8'h08,
		CIRC_PUSH_P = 8'h10,
		CIRC_VEC_L  = 8'h20,
		CIRC_VEC_H  = 8'h40,
		CIRC_RUN    = 8'h80
	} circ_state_e;
	typedef enum logic [4:0] {
		CIRC_OP_PCH  = 5'h01,
		CIRC_OP_PCL  = 5'h02,
		CIRC_OP_PSR  = 5'h04,
		CIRC_OP_VLO  = 5'h08,
		CIRC_OP_VHI  = 5'h10
	} circ_op_e;
	typedef struct packed {
		logic        valid;
		logic        write;
		circ_op_e    op;
		logic [15:0] addr;
	} circ_bus_op_s;
	typedef struct packed {
		logic instr_last;
		logic cycle_fetch;
		logic cycle_write;
		logic i_flag;
	} circ_core_s;
endpackage : circ_pkg
`default_nettype wire

// ---- rtl/circ_pin_sync.sv ----
// Three-stage pin synchroniser with agreement filter and edge pulses
`default_nettype none
module circ_pin_sync (
	input  wire logic ref_clk,
	input  wire logic reset,
	input  wire logic pin,
	output logic      level,
	output logic      fell,
	output logic      rose
);
	logic s1_reg;
	logic s2_reg;
	logic s3_reg;
	// ------------------------------------------------------------
	// Capture chain
	// ------------------------------------------------------------
	// Resets high: idle level of every active-low line
	always_ff @(posedge ref_clk) begin
		if (reset) begin
			s1_reg <= 1'b1;
			s2_reg <= 1'b1;
			s3_reg <= 1'b1;
		end else begin
			s1_reg <= pin;
			s2_reg <= s1_reg;
			s3_reg <= s2_reg;
		end
	end
	// ------------------------------------------------------------
	// Filtered level and edges
	// ------------------------------------------------------------
	always_ff @(posedge ref_clk) begin
		if (reset) begin
			level <= 1'b1;
			fell  <= 1'b0;
			rose  <= 1'b0;
		end else begin
			fell <= 1'b0;
			rose <= 1'b0;
			if (s2_reg == s3_reg && s3_reg != level) begin
				level <= s3_reg;
				fell  <= ~s3_reg;
				rose  <= s3_reg;
			end
		end
	end
endmodule : circ_pin_sync
`default_nettype wire

// ---- rtl/circ_cycle_cnt.sv ----
// Processor-cycle counter that pulses once a loaded count has elapsed
`default_nettype none
module circ_cycle_cnt (
	input  wire logic       ref_clk,
	input  wire logic       reset,
	input  wire logic       start,
	input  wire logic       tick,
	input  wire logic [2:0] count,
	output logic            done
);
	logic [2:0] left_reg;
	logic       busy_reg;
	always_ff @(posedge ref_clk) begin
		if (reset) begin
			left_reg <= 3'h0;
			busy_reg <= 1'b0;
			done     <= 1'b0;
		end else begin
			done <= 1'b0;
			if (start) begin
				left_reg <= count;
				busy_reg <= 1'b1;
			end else if (busy_reg && tick) begin
				left_reg <= left_reg - 3'h1;
				if (left_reg == 3'h1) begin
					busy_reg <= 1'b0;
					done     <= 1'b1;
				end
			end
		end
	end
endmodule : circ_cycle_cnt
`default_nettype wire

// ---- rtl/circ_ctrl.sv ----
// Interrupt, overflow, ready, opcode-fetch and reset sequencing for the core
// Notes on behaviour
// - Falling nonmaskable input edge registers a request
// - Nonmaskable runs interrupt sequence, ignores mask flag
// - Nonmaskable vector low FFFA, high FFFB
// - Sample interrupts phase two, start next phase one
// - Falling overflow input sets status overflow bit
// - Overflow input sampled at phase one trailing edge
// - Fetch indicator high only in opcode fetch cycles
// - Ready low at fetch freezes core until high
// - No bus writes while initialisation input low
// - Initialisation rising edge starts reset sequence immediately
// - Six cycles after release, set interrupt mask
// - Reset vector low FFFC, high FFFD, then run
// - Direction and fetch valid after minimum hold
// - Interrupt pushes program counter, then status
// - Mask flag set after stacking
// - No interrupt recognised while ready low
// - Ready low in write cycle waits for read
`default_nettype none
module circ_ctrl (
	input  wire logic                  ref_clk,
	input  wire logic                  reset,
	input  wire logic                  nmi_n,
	input  wire logic                  irq_n,
	input  wire logic                  so_n,
	input  wire logic                  rdy,
	input  wire logic                  chip_init_n,
	input  wire circ_pkg::circ_core_s  core,
	output logic                       phi1,
	output logic                       phi2,
	output logic                       core_step,
	output logic                       sync_out,
	output logic                       write_allow,
	output logic                       pins_valid,
	output logic                       set_v_flag,
	output logic                       set_i_flag,
	output circ_pkg::circ_bus_op_s     bus_op
);
	// ------------------------------------------------------------
	// Phase divider
	// ------------------------------------------------------------
	logic [1:0] ph_reg;
	logic       ph1_en;
	logic       ph1_trail;
	logic       ph2_smp;
	always_ff @(posedge ref_clk) begin
		if (reset) begin
			ph_reg <= 2'h0;
		end else begin
			ph_reg <= (ph_reg == circ_pkg::PH_LAST) ? 2'h0 : ph_reg + 2'h1;
		end
	end
	assign ph1_en    = ph_reg == circ_pkg::PH1_START;
	assign ph1_trail = ph_reg == circ_pkg::PH1_TRAIL;
	assign ph2_smp   = ph_reg == circ_pkg::PH2_SAMPLE;
	localparam logic [1:0] PH_BEFORE1 = circ_pkg::PH_LAST;
	always_ff @(posedge ref_clk) begin
		if (reset) begin
			phi1 <= 1'b0;
			phi2 <= 1'b0;
		end else begin
			phi1 <= ph_reg == PH_BEFORE1 || ph_reg == circ_pkg::PH1_START;
			phi2 <= ph_reg == circ_pkg::PH1_TRAIL || ph_reg == 2'h2;
		end
	end
	// ------------------------------------------------------------
	// Pin synchronisers
	// ------------------------------------------------------------
	logic nmi_lvl, nmi_fell;
	logic irq_lvl;
	logic so_lvl;
	logic rdy_lvl;
	logic init_lvl, init_rose, init_fell;
	circ_pin_sync u_nmi (.ref_clk(ref_clk), .reset(reset), .pin(nmi_n), .level(nmi_lvl), .fell(nmi_fell), .rose());
	circ_pin_sync u_irq (.ref_clk(ref_clk), .reset(reset), .pin(irq_n), .level(irq_lvl), .fell(), .rose());
	circ_pin_sync u_so (.ref_clk(ref_clk), .reset(reset), .pin(so_n), .level(so_lvl), .fell(), .rose());
	circ_pin_sync u_rdy (.ref_clk(ref_clk), .reset(reset), .pin(rdy), .level(rdy_lvl), .fell(), .rose());
	circ_pin_sync u_init (.ref_clk(ref_clk), .reset(reset), .pin(chip_init_n), .level(init_lvl),
		.fell(init_fell), .rose(init_rose));
	// ------------------------------------------------------------
	// Interrupt sampling
	// ------------------------------------------------------------
	logic nmi_prev_reg;
	logic nmi_pend_reg;
	logic irq_smp_reg;
	logic take_nmi;
	logic take_irq;
	logic seq_start;
	// Edge judged on phase-two samples so a held-low line cannot re-trigger
	always_ff @(posedge ref_clk) begin
		if (reset) begin
			nmi_prev_reg <= 1'b1;
			irq_smp_reg  <= 1'b0;
		end else if (ph2_smp) begin
			nmi_prev_reg <= nmi_lvl;
			irq_smp_reg  <= ~irq_lvl;
		end
	end
	always_ff @(posedge ref_clk) begin
		if (reset || !init_lvl) begin
			nmi_pend_reg <= 1'b0;
		end else if (ph2_smp && nmi_prev_reg && !nmi_lvl) begin
			nmi_pend_reg <= 1'b1;
		end else if (seq_start && take_nmi) begin
			nmi_pend_reg <= 1'b0;
		end
	end
	// ------------------------------------------------------------
	// Overflow input
	// ------------------------------------------------------------
	logic so_prev_reg;
	always_ff @(posedge ref_clk) begin
		if (reset) begin
			so_prev_reg <= 1'b1;
			set_v_flag  <= 1'b0;
		end else begin
			set_v_flag <= 1'b0;
			if (ph1_trail) begin
				so_prev_reg <= so_lvl;
				set_v_flag  <= so_prev_reg && !so_lvl && init_lvl;
			end
		end
	end
	// ------------------------------------------------------------
	// Sequencer
	// ------------------------------------------------------------
	circ_pkg::circ_state_e state_reg;
	logic                  boundary_reg;
	logic                  nmi_seq_reg;
	logic                  wait_done;
	logic                  may_run;
	logic [2:0]            init_cnt;
	logic                  state_is_int;
	// Ready is ignored on write cycles; the hold lands on the next read
	assign may_run   = rdy_lvl || core.cycle_write;
	assign take_nmi  = nmi_pend_reg;
	assign take_irq  = irq_smp_reg && !core.i_flag;
	assign seq_start = ph1_en && state_reg == circ_pkg::CIRC_RUN && boundary_reg && rdy_lvl
		&& (take_nmi || take_irq);
	assign init_cnt  = circ_pkg::RST_INIT_CYC;
	circ_cycle_cnt u_wait (.ref_clk(ref_clk), .reset(reset), .start(init_rose), .tick(ph1_en),
		.count(init_cnt), .done(wait_done));
	always_ff @(posedge ref_clk) begin
		if (reset || !init_lvl) begin
			state_reg <= circ_pkg::CIRC_HOLD;
		end else if (init_rose) begin
			state_reg <= circ_pkg::CIRC_WAIT;
		end else begin
			unique case (state_reg)
				circ_pkg::CIRC_HOLD: begin
					state_reg <= circ_pkg::CIRC_HOLD;
				end
				circ_pkg::CIRC_WAIT: begin
					if (wait_done) begin
						state_reg <= circ_pkg::CIRC_VEC_L;
					end
				end
				circ_pkg::CIRC_PUSH_H: begin
					if (ph1_en) state_reg <= circ_pkg::CIRC_PUSH_L;
				end
				circ_pkg::CIRC_PUSH_L: begin
					if (ph1_en) state_reg <= circ_pkg::CIRC_PUSH_P;
				end
				circ_pkg::CIRC_PUSH_P: begin
					if (ph1_en) state_reg <= circ_pkg::CIRC_VEC_L;
				end
				circ_pkg::CIRC_VEC_L: begin
					if (ph1_en && rdy_lvl) state_reg <= circ_pkg::CIRC_VEC_H;
				end
				circ_pkg::CIRC_VEC_H: begin
					if (ph1_en && rdy_lvl) state_reg <= circ_pkg::CIRC_RUN;
				end
				circ_pkg::CIRC_RUN: begin
					if (seq_start) state_reg <= circ_pkg::CIRC_PUSH_H;
				end
			endcase
		end
	end
	always_ff @(posedge ref_clk) begin
		if (reset || !init_lvl) begin
			nmi_seq_reg <= 1'b0;
		end else if (init_rose) begin
			nmi_seq_reg <= 1'b0;
		end else if (seq_start) begin
			nmi_seq_reg <= take_nmi;
		end
	end
	// ------------------------------------------------------------
	// Core stepping and fetch indicator
	// ------------------------------------------------------------
	assign core_step = ph1_en && state_reg == circ_pkg::CIRC_RUN && !seq_start && may_run;
	always_ff @(posedge ref_clk) begin
		if (reset || !init_lvl) begin
			boundary_reg <= 1'b0;
		end else if (seq_start) begin
			boundary_reg <= 1'b0;
		end else if (core_step) begin
			boundary_reg <= core.instr_last;
		end
	end
	// Frozen cycles keep their indicator, so a held fetch stays high
	always_ff @(posedge ref_clk) begin
		if (reset || !init_lvl) begin
			sync_out <= 1'b0;
		end else if (core_step) begin
			sync_out <= core.cycle_fetch;
		end else if (ph1_en && state_reg != circ_pkg::CIRC_RUN) begin
			sync_out <= 1'b0;
		end else if (seq_start) begin
			sync_out <= 1'b0;
		end
	end
	// ------------------------------------------------------------
	// Reset hold qualification and write gate
	// ------------------------------------------------------------
	logic [1:0] hold_cnt_reg;
	always_ff @(posedge ref_clk) begin
		if (reset) begin
			hold_cnt_reg <= 2'h0;
			pins_valid   <= 1'b0;
		end else if (!init_lvl) begin
			if (init_fell) begin
				hold_cnt_reg <= 2'h0;
			end else if (ph1_en && hold_cnt_reg != circ_pkg::RST_HOLD_CYC) begin
				hold_cnt_reg <= hold_cnt_reg + 2'h1;
			end
			if (hold_cnt_reg == circ_pkg::RST_HOLD_CYC) begin
				pins_valid <= 1'b1;
			end
		end
	end
	assign write_allow = init_lvl;
	// ------------------------------------------------------------
	// Bus operations and mask flag
	// ------------------------------------------------------------
	function automatic circ_pkg::circ_bus_op_s make_op(input circ_pkg::circ_op_e op, input logic [15:0] addr);
		circ_pkg::circ_bus_op_s r;
		r.valid = 1'b1;
		r.write = op == circ_pkg::CIRC_OP_PCH || op == circ_pkg::CIRC_OP_PCL || op == circ_pkg::CIRC_OP_PSR;
		r.op    = op;
		r.addr  = addr;
		return r;
	endfunction : make_op
	always_ff @(posedge ref_clk) begin
		if (reset || !init_lvl) begin
			bus_op <= '0;
		end else begin
			bus_op <= '0;
			if (ph1_en) begin
				unique case (state_reg)
					circ_pkg::CIRC_PUSH_H: bus_op <= make_op(circ_pkg::CIRC_OP_PCH, 16'h0000);
					circ_pkg::CIRC_PUSH_L: bus_op <= make_op(circ_pkg::CIRC_OP_PCL, 16'h0000);
					circ_pkg::CIRC_PUSH_P: bus_op <= make_op(circ_pkg::CIRC_OP_PSR, 16'h0000);
					circ_pkg::CIRC_VEC_L: if (rdy_lvl) bus_op <= make_op(circ_pkg::CIRC_OP_VLO,
						!state_is_int ? circ_pkg::RST_VEC_LO :
						nmi_seq_reg ? circ_pkg::NMI_VEC_LO : circ_pkg::IRQ_VEC_LO);
					circ_pkg::CIRC_VEC_H: if (rdy_lvl) bus_op <= make_op(circ_pkg::CIRC_OP_VHI,
						!state_is_int ? circ_pkg::RST_VEC_HI :
						nmi_seq_reg ? circ_pkg::NMI_VEC_HI : circ_pkg::IRQ_VEC_HI);
					default: bus_op <= '0;
				endcase
			end
		end
	end
	// Remembers whether the vector fetch belongs to an interrupt or to reset
	always_ff @(posedge ref_clk) begin
		if (reset || !init_lvl || init_rose) begin
			state_is_int <= 1'b0;
		end else if (seq_start) begin
			state_is_int <= 1'b1;
		end
	end
	always_ff @(posedge ref_clk) begin
		if (reset) begin
			set_i_flag <= 1'b0;
		end else begin
			set_i_flag <= init_lvl && ((state_reg == circ_pkg::CIRC_WAIT && wait_done)
				|| (state_reg == circ_pkg::CIRC_PUSH_P && ph1_en));
		end
	end
	// ------------------------------------------------------------
	// Assertions
	// ------------------------------------------------------------
	default clocking cb @(posedge ref_clk); endclocking
	default disable iff (reset);
	a_no_write_init: assert property (!init_lvl |-> !(bus_op.valid && bus_op.write) && !write_allow)
		else $error("write during initialisation hold");
	a_init_starts: assert property (init_rose |=> state_reg == circ_pkg::CIRC_WAIT)
		else $error("reset sequence did not start");
	a_nmi_latch: assert property (ph2_smp && nmi_prev_reg && !nmi_lvl && init_lvl |=> nmi_pend_reg)
		else $error("nmi edge lost");
	a_nmi_vector: assert property (bus_op.valid && bus_op.op == circ_pkg::CIRC_OP_VLO && nmi_seq_reg
		&& state_is_int |-> bus_op.addr == 16'hFFFA)
		else $error("wrong nmi vector");
	a_rst_vector: assert property (bus_op.valid && bus_op.op == circ_pkg::CIRC_OP_VHI && !state_is_int
		|-> bus_op.addr == 16'hFFFD)
		else $error("wrong reset vector");
	a_push_order: assert property (seq_start |=> state_reg == circ_pkg::CIRC_PUSH_H ##4
		bus_op.op == circ_pkg::CIRC_OP_PCH ##4 bus_op.op == circ_pkg::CIRC_OP_PCL)
		else $error("stack order wrong");
	a_mask_after: assert property ($rose(set_i_flag) && state_is_int |-> $past(state_reg) == circ_pkg::CIRC_PUSH_P)
		else $error("mask set at wrong time");
	a_rdy_blocks: assert property (!rdy_lvl |-> !seq_start)
		else $error("interrupt taken with ready low");
	a_fetch_freeze: assert property (ph1_en && sync_out && !rdy_lvl && !core.cycle_write |-> !core_step)
		else $error("core stepped while held");
	a_write_ignore: assert property (ph1_en && state_reg == circ_pkg::CIRC_RUN && !seq_start && core.cycle_write
		|-> core_step)
		else $error("write cycle held by ready");
	a_v_pulse: assert property (set_v_flag |-> $past(ph1_trail) && !so_prev_reg)
		else $error("overflow set without edge");
	a_sync_low: assert property (state_reg != circ_pkg::CIRC_RUN ##4 state_reg != circ_pkg::CIRC_RUN
		|-> !sync_out)
		else $error("fetch indicator outside run");
	c_nmi_seq: cover property (seq_start && take_nmi);
	c_irq_seq: cover property (seq_start && !take_nmi);
	c_reset_run: cover property (state_reg == circ_pkg::CIRC_VEC_H ##[1:8] state_reg == circ_pkg::CIRC_RUN);
	c_step_hold: cover property (ph1_en && sync_out && !rdy_lvl);
endmodule : circ_ctrl
`default_nettype wire

// ---- tb/circ_core_model.sv ----
// Behavioural core and system model facing the control unit
`default_nettype none
module circ_core_model (
	input  wire logic            ref_clk,
	input  wire logic            reset,
	input  wire logic            core_step,
	input  wire logic            set_i_flag,
	input  wire logic            clr_i,
	input  wire logic            wr_mode,
	output circ_pkg::circ_core_s core
);
	timeunit 1ns;
	timeprecision 1ps;
	// ------------------------------------------------------------
	// Instruction cycles
	// ------------------------------------------------------------
	logic phase_reg;
	logic mask_reg;
	// Two-cycle instructions keep every boundary close; write mode makes the last cycle a write
	always_ff @(posedge ref_clk) begin
		if (reset) begin
			phase_reg <= 1'b0;
		end else if (core_step) begin
			phase_reg <= ~phase_reg;
		end
	end
	// ------------------------------------------------------------
	// Mask flag
	// ------------------------------------------------------------
	// Clear stands in for software; set only by the unit
	always_ff @(posedge ref_clk) begin
		if (reset || clr_i) begin
			mask_reg <= 1'b0;
		end else if (set_i_flag) begin
			mask_reg <= 1'b1;
		end
	end
	assign core = '{instr_last: phase_reg, cycle_fetch: ~phase_reg, cycle_write: phase_reg & wr_mode, i_flag: mask_reg};
endmodule : circ_core_model
`default_nettype wire

// ---- tb/cpu_interrupt_reset_control_bench.sv ----
// Self-checking bench for the interrupt and reset control unit
`default_nettype none
module cpu_interrupt_reset_control_bench;
	timeunit 1ns;
	timeprecision 1ps;
	// ------------------------------------------------------------
	// Signals and instances
	// ------------------------------------------------------------
	logic                   ref_clk = 1'b0;
	logic                   reset = 1'b1;
	logic                   nmi_n = 1'b1;
	logic                   irq_n = 1'b1;
	logic                   so_n = 1'b1;
	logic                   rdy = 1'b1;
	logic                   chip_init_n = 1'b0;
	logic                   clr_i = 1'b0;
	logic                   wr_mode = 1'b0;
	logic                   phi1, phi2;
	logic                   seti_seen = 1'b0;
	circ_pkg::circ_core_s   core;
	circ_pkg::circ_bus_op_s bus_op;
	logic                   core_step, sync_out, write_allow, pins_valid, set_v_flag, set_i_flag;
	int                     fails = 0;
	int                     check_count = 0;
	int                     cyc = 0;
	always #12.5 ref_clk = ~ref_clk;
	circ_ctrl dut_u (.ref_clk(ref_clk), .reset(reset), .nmi_n(nmi_n), .irq_n(irq_n), .so_n(so_n),
		.rdy(rdy), .chip_init_n(chip_init_n), .core(core), .phi1(phi1), .phi2(phi2), .core_step(core_step),
		.sync_out(sync_out), .write_allow(write_allow), .pins_valid(pins_valid),
		.set_v_flag(set_v_flag), .set_i_flag(set_i_flag), .bus_op(bus_op));
	circ_core_model model_u (.ref_clk(ref_clk), .reset(reset), .core_step(core_step),
		.set_i_flag(set_i_flag), .clr_i(clr_i), .wr_mode(wr_mode), .core(core));
	// ------------------------------------------------------------
	// Shared tasks
	// ------------------------------------------------------------
	task automatic conclude();
		if (fails == 0 && check_count > 0) begin
			$display("All checks passed");
		end else begin
			$display("Checks failed");
		end
		$finish;
	endtask : conclude
	task automatic check(input string name, input logic [15:0] seen, input logic [15:0] exp);
		check_count++;
		if (seen !== exp) begin
			fails++;
			$display("ERROR %s expected %h seen %h", name, exp, seen);
		end
	endtask : check
	task automatic next_op(output circ_pkg::circ_bus_op_s op);
		op = '0;
		repeat (200) begin
			@(posedge ref_clk);
			#1;
			op = bus_op;
			if (bus_op.valid === 1'b1) break;
		end
	endtask : next_op
	task automatic quiet(input int n, output int ops, output int steps);
		ops = 0;
		steps = 0;
		repeat (n) begin
			@(posedge ref_clk);
			#1;
			ops += int'(bus_op.valid === 1'b1);
			steps += int'(core_step === 1'b1);
		end
	endtask : quiet
	task automatic check_seq(input logic [15:0] lo, input logic [15:0] hi, input logic push);
		circ_pkg::circ_bus_op_s op;
		circ_pkg::circ_op_e     pushes [3] = '{circ_pkg::CIRC_OP_PCH, circ_pkg::CIRC_OP_PCL, circ_pkg::CIRC_OP_PSR};
		if (push) begin
			foreach (pushes[i]) begin
				next_op(op);
				check("push order", {op.write, op.op}, {1'b1, pushes[i]});
			end
			check("mask before pushes end", seti_seen, 1'b0);
		end
		next_op(op);
		check("mask set before vector", seti_seen, 1'b1);
		check("vector low op", {op.write, op.op}, {1'b0, circ_pkg::CIRC_OP_VLO});
		check("vector low addr", op.addr, lo);
		next_op(op);
		check("vector high op", {op.write, op.op}, {1'b0, circ_pkg::CIRC_OP_VHI});
		check("vector high addr", op.addr, hi);
	endtask : check_seq
	// ------------------------------------------------------------
	// Scenarios
	// ------------------------------------------------------------
	task automatic t_reset();
		int n;
		repeat (4) @(posedge ref_clk);
		#1;
		check("pins valid early", pins_valid, 1'b0);
		repeat (16) @(posedge ref_clk);
		#1;
		check("write allow in init", write_allow, 1'b0);
		check("pins valid", pins_valid, 1'b1);
		seti_seen = 1'b0;
		@(posedge ref_clk);
		chip_init_n <= 1'b1;
		n = 0;
		repeat (100) begin
			@(posedge ref_clk);
			#1;
			n++;
			if (set_i_flag === 1'b1) break;
		end
		check("init interval", 16'(n >= 22 && n <= 36), 16'h0001);
		check_seq(16'hFFFC, 16'hFFFD, 1'b0);
		check("write allow after init", write_allow, 1'b1);
	endtask : t_reset
	task automatic t_nmi();
		int ops, steps;
		seti_seen = 1'b0;
		@(posedge ref_clk);
		nmi_n <= 1'b0;
		// Mask is already set, so only the nonmaskable path may answer
		check_seq(16'hFFFA, 16'hFFFB, 1'b1);
		quiet(120, ops, steps);
		check("held low no repeat", 16'(ops), 16'h0000);
		@(posedge ref_clk);
		nmi_n <= 1'b1;
		repeat (20) @(posedge ref_clk);
	endtask : t_nmi
	task automatic t_irq();
		int ops, steps;
		@(posedge ref_clk);
		irq_n <= 1'b0;
		quiet(60, ops, steps);
		check("masked request ignored", 16'(ops), 16'h0000);
		seti_seen = 1'b0;
		@(posedge ref_clk);
		clr_i <= 1'b1;
		@(posedge ref_clk);
		clr_i <= 1'b0;
		check_seq(16'hFFFE, 16'hFFFF, 1'b1);
		@(posedge ref_clk);
		irq_n <= 1'b1;
		repeat (20) @(posedge ref_clk);
	endtask : t_irq
	task automatic t_rdy();
		int ops, steps;
		@(posedge ref_clk);
		rdy <= 1'b0;
		nmi_n <= 1'b0;
		wr_mode <= 1'b1;
		quiet(20, ops, steps);
		quiet(60, ops, steps);
		check("no interrupt while held", 16'(ops), 16'h0000);
		check("core frozen at fetch", 16'(steps), 16'h0000);
		check("held on read cycle", {14'h0000, core.cycle_fetch, core.cycle_write}, 16'h0002);
		seti_seen = 1'b0;
		@(posedge ref_clk);
		rdy <= 1'b1;
		check_seq(16'hFFFA, 16'hFFFB, 1'b1);
		@(posedge ref_clk);
		nmi_n <= 1'b1;
	endtask : t_rdy
	task automatic t_sync();
		logic fetch;
		repeat (8) begin
			do begin
				@(posedge ref_clk);
				#1;
			end while (core_step !== 1'b1 && cyc < 19000);
			fetch = core.cycle_fetch;
			check("phase one at step", {14'h0000, phi1, phi2}, 16'h0002);
			repeat (2) @(posedge ref_clk);
			#1;
			check("fetch indicator", sync_out, fetch);
			check("phase two mid cycle", {14'h0000, phi1, phi2}, 16'h0001);
		end
	endtask : t_sync
	task automatic t_so();
		int n;
		// Driven on the clock edge, so already synchronous
		@(posedge ref_clk);
		so_n <= 1'b0;
		n = 0;
		repeat (30) begin
			@(posedge ref_clk);
			#1;
			n += int'(set_v_flag === 1'b1);
		end
		check("overflow set once", 16'(n), 16'h0001);
		@(posedge ref_clk);
		so_n <= 1'b1;
		n = 0;
		repeat (30) begin
			@(posedge ref_clk);
			#1;
			n += int'(set_v_flag === 1'b1);
		end
		check("rising edge sets nothing", 16'(n), 16'h0000);
	endtask : t_so
	// ------------------------------------------------------------
	// Monitors and main sequence
	// ------------------------------------------------------------
	always @(posedge ref_clk) begin
		if (set_i_flag === 1'b1) seti_seen = 1'b1;
		if (!reset && chip_init_n === 1'b0 && bus_op.valid === 1'b1) begin
			check("bus op in init", {15'h0000, bus_op.write}, 16'h0000);
		end
		cyc++;
		if (cyc == 20000) begin
			fails++;
			conclude();
		end
	end
	initial begin
		repeat (20) @(posedge ref_clk);
		// Init input stays low well past reset release
		reset <= 1'b0;
		t_reset();
		t_nmi();
		t_irq();
		t_rdy();
		t_sync();
		t_so();
		conclude();
	end
endmodule : cpu_interrupt_reset_control_bench
`default_nettype wire
